// *** hw/adcsq_top.sv ***
// Conversion sequencer: APB registers, start and channel control, pin sharing.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module adcsq_top #(
  parameter int CONV_CYCLES = adcsq_pkg::CONV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [adcsq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [adcsq_pkg::DATA_W-1:0] pwdata_i,
  output logic [adcsq_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_trigger_input_i,
  input wire logic comparator_i,
  output logic [adcsq_pkg::CH_W-1:0] channel_select_o,
  output logic [adcsq_pkg::NUM_CH-1:0] analog_channel_inputs_en_o,
  output logic [adcsq_pkg::RES_W-1:0] dac_code_o,
  output logic sample_o,
  output logic conversion_done_request_o,
  output logic irq_o,
  input wire logic wait_pin_i,
  output logic wait_o,
  input wire logic refresh_pulse_i,
  output logic refresh_pulse_output_o,
  output logic refresh_pulse_output_oe_o
);

  adcsq_core_if core_if ();

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic trig_prev_ff;
  logic trig_edge;
  logic [7:0] mode_ff;
  logic [1:0] pin_func_ff;
  logic [adcsq_pkg::RES_W-1:0] result_ff;
  logic [adcsq_pkg::CH_W-1:0] res_ch_ff;
  logic [adcsq_pkg::CH_W-1:0] chan_ff;
  logic done_sts_ff;
  logic done_mask_ff;
  logic done_req_ff;
  logic start_ff;
  logic abort_ff;
  logic [adcsq_pkg::DATA_W-1:0] prdata_ff;
  adcsq_pkg::adcsq_ctl_t ctl_ff;
  logic run;
  logic hw_mode;
  logic sel_mode;
  logic [adcsq_pkg::CH_W-1:0] sel_ch;
  logic [adcsq_pkg::CH_W-1:0] first_ch;
  logic accept;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic [adcsq_pkg::DATA_W-1:0] rd_val;

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  // Release is synchronous so no flop leaves reset a cycle apart from its neighbours.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
      trig_prev_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= {wait_pin_i, comparator_i, external_trigger_input_i};
      pin_sync_ff <= pin_meta_ff;
      trig_prev_ff <= pin_sync_ff[0];
    end
  end

  // A rising edge of the trigger pin is the hardware start event.
  // The pin is taken to rest low; a pin resting high would fake an edge after reset.
  assign trig_edge = pin_sync_ff[0] && !trig_prev_ff;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always_comb
  begin
    hit = 1'b1;
    rd_val = '0;
    unique case (paddr_i)
      adcsq_pkg::OFS_CONVERSION_MODE_REGISTER: rd_val[7:0] = mode_ff;
      adcsq_pkg::OFS_CONVERSION_RESULT_REGISTER:
      begin
        rd_val[adcsq_pkg::RES_W-1:0] = result_ff;
        rd_val[adcsq_pkg::RES_CH_LSB +: adcsq_pkg::CH_W] = res_ch_ff;
      end
      adcsq_pkg::OFS_STATUS:
      begin
        rd_val[adcsq_pkg::STS_DONE_BIT] = done_sts_ff;
        rd_val[adcsq_pkg::STS_BUSY_BIT] = core_if.busy;
      end
      adcsq_pkg::OFS_MASK: rd_val[adcsq_pkg::STS_DONE_BIT] = done_mask_ff;
      adcsq_pkg::OFS_PIN_FUNC: rd_val[1:0] = pin_func_ff;
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so the access phase needs no wait.
  // Every register answers at once, so pready is tied high and no access waits.
  // A read returns the value seen in its setup cycle, not one changed during access.
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign wr_en = psel_i && penable_i && pwrite_i && hit;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign prdata_o = prdata_ff;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      prdata_ff <= '0;
    else if (rd_setup)
      prdata_ff <= rd_val;
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Start source, scan or select, channel and run/stop live in one register.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= adcsq_pkg::MODE_RST;
    else if (wr_en && paddr_i == adcsq_pkg::OFS_CONVERSION_MODE_REGISTER)
      mode_ff <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pin_func_ff <= adcsq_pkg::PIN_FUNC_RST;
    else if (wr_en && paddr_i == adcsq_pkg::OFS_PIN_FUNC)
      pin_func_ff <= pwdata_i[1:0];
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      done_mask_ff <= 1'b0;
    else if (wr_en && paddr_i == adcsq_pkg::OFS_MASK)
      done_mask_ff <= pwdata_i[adcsq_pkg::STS_DONE_BIT];
  end

  assign run = mode_ff[adcsq_pkg::MODE_RUN_BIT];
  assign hw_mode = mode_ff[adcsq_pkg::MODE_HW_BIT];
  assign sel_mode = mode_ff[adcsq_pkg::MODE_SEL_BIT];
  assign sel_ch = mode_ff[adcsq_pkg::MODE_CH_LSB +: adcsq_pkg::CH_W];
  assign first_ch = sel_mode ? sel_ch : adcsq_pkg::CH_FIRST;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A trigger edge in mid conversion restarts from the first channel and drops the
  // running result, trading that result for a prompt restart.
  // A done seen while a start is in flight belongs to a dropped conversion.
  assign accept = (ctl_ff == adcsq_pkg::CTL_CONV) && core_if.done && !start_ff && run
    && !(hw_mode && trig_edge);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_ff <= adcsq_pkg::CTL_IDLE;
      chan_ff <= adcsq_pkg::CH_FIRST;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      unique case (ctl_ff)
        adcsq_pkg::CTL_IDLE:
        begin
          if (run && hw_mode)
            ctl_ff <= adcsq_pkg::CTL_WAIT_TRIG;
          else if (run)
          begin
            ctl_ff <= adcsq_pkg::CTL_CONV;
            chan_ff <= first_ch;
            start_ff <= 1'b1;
          end
        end
        adcsq_pkg::CTL_WAIT_TRIG:
        begin
          if (!run || !hw_mode)
            ctl_ff <= adcsq_pkg::CTL_IDLE;
          else if (trig_edge)
          begin
            ctl_ff <= adcsq_pkg::CTL_CONV;
            chan_ff <= first_ch;
            start_ff <= 1'b1;
          end
        end
        adcsq_pkg::CTL_CONV:
        begin
          if (!run)
          begin
            ctl_ff <= adcsq_pkg::CTL_IDLE;
            abort_ff <= 1'b1;
          end
          else if (hw_mode && trig_edge)
          begin
            chan_ff <= first_ch;
            start_ff <= 1'b1;
          end
          else if (accept)
          begin
            // Select holds its channel, scan steps up and wraps by overflow.
            chan_ff <= sel_mode ? sel_ch : chan_ff + 1'b1;
            start_ff <= 1'b1;
          end
        end
        // The unused fourth code of the state register falls back to idle.
        default: ctl_ff <= adcsq_pkg::CTL_IDLE;
      endcase
    end
  end

  assign core_if.start = start_ff;
  assign core_if.abort = abort_ff;
  assign core_if.cmp = pin_sync_ff[1];

  adcsq_sar #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_sar (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .bus(core_if)
  );

  // ----------------------------------------------------------------------
  // Result, done request and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_ff <= adcsq_pkg::RESULT_RST;
      res_ch_ff <= adcsq_pkg::CH_FIRST;
    end
    else if (accept)
    begin
      result_ff <= core_if.result;
      res_ch_ff <= chan_ff;
    end
  end

  // The pulse doubles as a transfer request, one per stored result except in software-started select mode.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      done_req_ff <= 1'b0;
    else
      done_req_ff <= accept && !(sel_mode && !hw_mode);
  end

  // A new request in the clearing cycle keeps the flag set.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      done_sts_ff <= 1'b0;
    else if (done_req_ff)
      done_sts_ff <= 1'b1;
    else if (wr_en && paddr_i == adcsq_pkg::OFS_STATUS && pwdata_i[adcsq_pkg::STS_DONE_BIT])
      done_sts_ff <= 1'b0;
  end

  assign conversion_done_request_o = done_req_ff;
  assign irq_o = done_sts_ff && done_mask_ff;

  // ----------------------------------------------------------------------
  // Analog routing and shared pins
  // ----------------------------------------------------------------------
  // Only one channel reaches the core; shared pins join only in analog use.
  assign channel_select_o = chan_ff;
  assign dac_code_o = core_if.dac_code;
  assign sample_o = core_if.sample;

  // Converting channel six or seven while its pin keeps the digital role still runs
  // the core, but the switch stays open and that result carries no meaning.
  genvar g;
  generate
    for (g = 0; g < adcsq_pkg::NUM_CH; g++)
    begin : g_ch_en
      if (g == adcsq_pkg::CH_SHARED_LO)
      begin : g_lo
        assign analog_channel_inputs_en_o[g] = pin_func_ff[adcsq_pkg::PIN_CH6_BIT] &&
          (chan_ff == adcsq_pkg::CH_W'(g));
      end
      else if (g == adcsq_pkg::CH_SHARED_HI)
      begin : g_hi
        assign analog_channel_inputs_en_o[g] = pin_func_ff[adcsq_pkg::PIN_CH7_BIT] &&
          (chan_ff == adcsq_pkg::CH_W'(g));
      end
      else
      begin : g_plain
        assign analog_channel_inputs_en_o[g] = (chan_ff == adcsq_pkg::CH_W'(g));
      end
    end
  endgenerate

  // A pin in analog use drops its digital role entirely.
  assign wait_o = pin_sync_ff[2] && !pin_func_ff[adcsq_pkg::PIN_CH6_BIT];
  assign refresh_pulse_output_oe_o = !pin_func_ff[adcsq_pkg::PIN_CH7_BIT];
  assign refresh_pulse_output_o = refresh_pulse_i && !pin_func_ff[adcsq_pkg::PIN_CH7_BIT];

endmodule // adcsq_top

// *** inc/adcsq_pkg.sv ***
// Constants, register map and state types of the conversion sequencer.
package adcsq_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONVERSION_MODE_REGISTER = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONVERSION_RESULT_REGISTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PIN_FUNC = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_HW_BIT = 1;
  localparam int MODE_SEL_BIT = 2;
  localparam int MODE_CH_LSB = 4;
  localparam int RES_CH_LSB = 8;
  localparam int STS_DONE_BIT = 0;
  localparam int STS_BUSY_BIT = 8;
  localparam int PIN_CH6_BIT = 0;
  localparam int PIN_CH7_BIT = 1;
  localparam int CH_SHARED_LO = 6;
  localparam int CH_SHARED_HI = 7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] PIN_FUNC_RST = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
  localparam logic [CH_W-1:0] CH_FIRST = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 40;
  localparam int CONV_TIME_NS = 30000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int SAMPLE_STEPS = 2;
  localparam int STEP_W = 12;

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CTL_IDLE, CTL_WAIT_TRIG, CTL_CONV} adcsq_ctl_t;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} adcsq_sar_t;

endpackage

// *** inc/adcsq_core_if.sv ***
// Signals between the sequencer control and the approximation core.
`timescale 1ns/100ps
interface adcsq_core_if;
  logic start;
  logic abort;
  logic cmp;
  logic busy;
  logic done;
  logic sample;
  logic [adcsq_pkg::RES_W-1:0] dac_code;
  logic [adcsq_pkg::RES_W-1:0] result;

  modport ctrl (output start, output abort, output cmp,
                input busy, input done, input sample, input dac_code, input result);
  modport core (input start, input abort, input cmp,
                output busy, output done, output sample, output dac_code, output result);
endinterface

// *** hw/adcsq_sar.sv ***
// Successive approximation core: sample phase, then one trial per result bit.
`timescale 1ns/100ps
module adcsq_sar #(
  parameter int CONV_CYCLES = adcsq_pkg::CONV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  adcsq_core_if.core bus
);

  localparam int STEPS = adcsq_pkg::RES_W + adcsq_pkg::SAMPLE_STEPS;
  localparam logic [adcsq_pkg::STEP_W-1:0] STEP_LAST =
    adcsq_pkg::STEP_W'(CONV_CYCLES / STEPS - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'(adcsq_pkg::SAMPLE_STEPS - 1);
  localparam logic [3:0] BIT_MSB = 4'(adcsq_pkg::RES_W - 1);
  localparam logic [adcsq_pkg::RES_W-1:0] TRIAL_FIRST =
    {1'b1, {(adcsq_pkg::RES_W - 1){1'b0}}};

  adcsq_pkg::adcsq_sar_t state_ff;
  logic [adcsq_pkg::STEP_W-1:0] div_ff;
  logic [3:0] idx_ff;
  logic [adcsq_pkg::RES_W-1:0] code_ff;
  logic [adcsq_pkg::RES_W-1:0] result_ff;
  logic done_ff;
  logic tick;

  // ----------------------------------------------------------------------
  // Step divider
  // ----------------------------------------------------------------------
  assign tick = (div_ff == STEP_LAST);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_ff <= '0;
    else if (bus.start || tick || state_ff == adcsq_pkg::SAR_IDLE)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Approximation sequence
  // ----------------------------------------------------------------------
  // A start always wins, so a restart needs no separate abort.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= adcsq_pkg::SAR_IDLE;
      idx_ff <= '0;
      code_ff <= '0;
      result_ff <= adcsq_pkg::RESULT_RST;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (bus.start)
      begin
        state_ff <= adcsq_pkg::SAR_SAMPLE;
        idx_ff <= '0;
        code_ff <= '0;
      end
      else if (bus.abort)
        state_ff <= adcsq_pkg::SAR_IDLE;
      else if (tick)
      begin
        unique case (state_ff)
          adcsq_pkg::SAR_IDLE: ;
          adcsq_pkg::SAR_SAMPLE:
          begin
            if (idx_ff == SAMPLE_LAST)
            begin
              state_ff <= adcsq_pkg::SAR_CONVERT;
              idx_ff <= BIT_MSB;
              code_ff <= TRIAL_FIRST;
            end
            else
              idx_ff <= idx_ff + 1'b1;
          end
          adcsq_pkg::SAR_CONVERT:
          begin
            // Trial bit stays when the input is at or above the trial level.
            code_ff[idx_ff[2:0]] <= bus.cmp;
            if (idx_ff == 4'h0)
            begin
              result_ff <= {code_ff[adcsq_pkg::RES_W-1:1], bus.cmp};
              done_ff <= 1'b1;
              state_ff <= adcsq_pkg::SAR_IDLE;
            end
            else
            begin
              code_ff[idx_ff[2:0] - 3'h1] <= 1'b1;
              idx_ff <= idx_ff - 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign bus.busy = (state_ff != adcsq_pkg::SAR_IDLE);
  assign bus.sample = (state_ff == adcsq_pkg::SAR_SAMPLE);
  assign bus.dac_code = code_ff;
  assign bus.result = result_ff;
  assign bus.done = done_ff;

endmodule // adcsq_sar

// *** bench/adcsq_top_asserts.sv ***
// Port-level concurrent checks for the conversion sequencer top.
`timescale 1ns/100ps
module adcsq_chk #(
  parameter int CONV_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [adcsq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic [adcsq_pkg::CH_W-1:0] channel_select_o,
  input wire logic [adcsq_pkg::NUM_CH-1:0] analog_channel_inputs_en_o,
  input wire logic sample_o,
  input wire logic conversion_done_request_o,
  input wire logic wait_o,
  input wire logic refresh_pulse_output_o,
  input wire logic refresh_pulse_output_oe_o
);
  // --------------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------------
  // Only an upper bound on the sample phase: an abort may cut it short.
  localparam int SMP = 2 * (CONV_CYCLES / 10);
  logic [15:0] smp_cnt_ff;
  logic [15:0] gap_ff;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      smp_cnt_ff <= 16'h0000;
      gap_ff <= 16'hFFFF;
    end
    else
    begin
      smp_cnt_ff <= sample_o ? smp_cnt_ff + 16'h0001 : 16'h0000;
      gap_ff <= conversion_done_request_o ? 16'h0000 :
                (gap_ff == 16'hFFFF ? gap_ff : gap_ff + 16'h0001);
    end
  end

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  switch_one_hot_a: assert property (
    (analog_channel_inputs_en_o == 8'h00) ||
    (analog_channel_inputs_en_o == (8'h01 << channel_select_o)))
    else $error("switch enable is not the selected channel");
  chan_hold_a: assert property (
    sample_o ##1 sample_o |-> $stable(channel_select_o))
    else $error("channel moved during sampling");
  err_phase_a: assert property (
    pslverr_o |-> psel_i && penable_i)
    else $error("slave error outside access phase");
  err_hole_a: assert property (
    psel_i && penable_i && paddr_i > 8'h10 |-> pslverr_o)
    else $error("unmapped access not refused");
  map_ok_a: assert property (
    psel_i && penable_i && paddr_i[1:0] == 2'h0 && paddr_i <= 8'h10 |-> !pslverr_o)
    else $error("mapped access refused");
  wait_gate_a: assert property (
    analog_channel_inputs_en_o[6] |-> !wait_o)
    else $error("wait active while pin is analog");
  refresh_oe_a: assert property (
    analog_channel_inputs_en_o[7] |-> !refresh_pulse_output_oe_o)
    else $error("refresh driver on while pin is analog");
  refresh_off_a: assert property (
    !refresh_pulse_output_oe_o |-> !refresh_pulse_output_o)
    else $error("refresh pulse while driver off");
  done_pulse_a: assert property (
    conversion_done_request_o |=> !conversion_done_request_o)
    else $error("done request longer than one cycle");
  done_gap_a: assert property (
    conversion_done_request_o |-> gap_ff >= 16'(CONV_CYCLES - 1))
    else $error("results closer than one conversion time");
  sample_len_a: assert property (
    sample_o |-> smp_cnt_ff < 16'(SMP + 1))
    else $error("sample phase too long");
endmodule // adcsq_chk

bind adcsq_top adcsq_chk #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pslverr_o(pslverr_o), .channel_select_o(channel_select_o),
  .analog_channel_inputs_en_o(analog_channel_inputs_en_o), .sample_o(sample_o),
  .conversion_done_request_o(conversion_done_request_o), .wait_o(wait_o),
  .refresh_pulse_output_o(refresh_pulse_output_o),
  .refresh_pulse_output_oe_o(refresh_pulse_output_oe_o));

// *** bench/tb_top.sv ***
// Self-checking bench for the conversion sequencer top.
`timescale 1ns/100ps
module tb_top;
  // --------------------------------------------------------------------
  // Signals and design
  // --------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic external_trigger_input_i = 1'b0;
  logic comparator_i = 1'b0;
  logic wait_pin_i = 1'b0;
  logic refresh_pulse_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, sample_o, conversion_done_request_o, irq_o, wait_o;
  logic [2:0] channel_select_o;
  logic [7:0] analog_channel_inputs_en_o, dac_code_o;
  logic refresh_pulse_output_o, refresh_pulse_output_oe_o;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int done_cnt = 0;
  int d0;
  int tgt [8];
  logic [31:0] rd;
  logic err;
  wire [2:0] pin_use = {wait_o, refresh_pulse_output_o, refresh_pulse_output_oe_o};

  adcsq_top #(.CONV_CYCLES(80)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_trigger_input_i(external_trigger_input_i), .comparator_i(comparator_i),
    .channel_select_o(channel_select_o),
    .analog_channel_inputs_en_o(analog_channel_inputs_en_o), .dac_code_o(dac_code_o),
    .sample_o(sample_o), .conversion_done_request_o(conversion_done_request_o),
    .irq_o(irq_o), .wait_pin_i(wait_pin_i), .wait_o(wait_o),
    .refresh_pulse_i(refresh_pulse_i), .refresh_pulse_output_o(refresh_pulse_output_o),
    .refresh_pulse_output_oe_o(refresh_pulse_output_oe_o));

  always #12.5 clk_i = ~clk_i;

  // The analog level of each channel is a random code; the comparator answers it.
  always @(posedge clk_i)
    comparator_i <= (tgt[channel_select_o] >= int'(dac_code_o));

  always @(negedge clk_i)
    if (conversion_done_request_o === 1'b1)
      done_cnt++;

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic finish_test();
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // Only the bench timeout ends a wait for the answer.
    while (pready_o !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    check(n, 32'h0, "wait states");
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    @(negedge clk_i);
    while (conversion_done_request_o !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    check({31'h0, n < 400}, 32'h1, "conversion finished");
  endtask

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial
  begin
    void'($urandom(16612));
    foreach (tgt[i])
      tgt[i] = $urandom_range(255);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int a = 0; a <= 20; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0, "reset value");
      check({31'h0, err}, {31'h0, a == 20}, "slave error");
    end
    apb(1'b1, 8'h04, 32'hFF);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0, "result is read only");
    wait_pin_i <= 1'b1;
    refresh_pulse_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({29'h0, pin_use}, 32'h7, "port use");
    apb(1'b1, 8'h10, 32'h3);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({29'h0, pin_use}, 32'h0, "analog use");
    wait_pin_i <= 1'b0;
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      wait_done();
      apb(1'b0, 8'h04, 32'h0);
      check(rd, {21'h0, 3'(i % 8), 8'(tgt[i % 8])}, "scan result");
      apb(1'b0, 8'h08, 32'h0);
      check(rd & 32'h101, 32'h101, "done and busy");
    end
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h1, "irq pending");
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk_i);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h1, "stopped status");
    apb(1'b1, 8'h0C, 32'h0);
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0, "masked irq");
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    @(negedge clk_i);
    check({31'h0, irq_o}, 32'h0, "cleared irq");
    d0 = done_cnt;
    apb(1'b1, 8'h00, 32'h55);
    repeat (150) @(posedge clk_i);
    tgt[5] = $urandom_range(255);
    repeat (250) @(posedge clk_i);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, {21'h0, 3'h5, 8'(tgt[5])}, "select result");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h100, "select status");
    check(done_cnt - d0, 32'h0, "no request in select");
    apb(1'b1, 8'h00, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      d0 = done_cnt;
      apb(1'b1, 8'h00, m ? 32'h37 : 32'h03);
      repeat (200) @(posedge clk_i);
      check(done_cnt - d0, 32'h0, "armed only");
      external_trigger_input_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      external_trigger_input_i <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        wait_done();
        apb(1'b0, 8'h04, 32'h0);
        check(rd, {21'h0, 3'(m ? 3 : i), 8'(tgt[m ? 3 : i])}, "triggered result");
      end
      apb(1'b1, 8'h00, 32'h0);
    end
    finish_test();
  end
endmodule // tb_top
